// file: hdl/spsp_pkg.sv
package spsp_pkg;
   localparam int DATA_W = 128;
   localparam int TAIL_W = 4;
   // Tail count on every egress word but the last: all ones
   localparam logic [TAIL_W-1:0] TAIL_FULL = 4'hF;
   // Longest legal packet in words before it is called malformed
   localparam int MAX_WORDS = 4096;
   localparam int WCNT_W = 13;
   localparam logic [WCNT_W-1:0] WCNT_ZERO = 13'h0000;
   localparam logic [WCNT_W-1:0] WCNT_ONE = 13'h0001;
   localparam logic [DATA_W-1:0] DATA_ZERO = 128'h0;

   typedef enum logic [1:0] {
      SPSP_IDLE = 2'b01,
      SPSP_IN_PKT = 2'b10
   } spsp_pkt_state_t;

   typedef struct packed {
      logic sa_missing;
      logic malformed_packet;
      logic integrity_mismatch;
      logic replay_reject;
      logic unencrypted;
   } spsp_status_t;

   localparam spsp_status_t STATUS_CLEAR = 5'h00;
endpackage

// file: hdl/spsp_if.sv
`timescale 1ns/1ps
interface spsp_if;
   logic cen;
   logic [spsp_pkg::DATA_W-1:0] ingress_data;
   logic ingress_valid;
   logic ingress_ready;
   logic ingress_first;
   logic ingress_last;
   logic [spsp_pkg::TAIL_W-1:0] ingress_tail_bytes;
   logic [spsp_pkg::DATA_W-1:0] egress_data;
   logic egress_valid;
   logic egress_ready;
   logic [spsp_pkg::TAIL_W-1:0] egress_tail_bytes;
   logic done;
   logic sa_missing;
   logic malformed_packet;
   logic integrity_mismatch;
   logic replay_reject;
   logic unencrypted;

   modport dev (
      input cen,
      input ingress_data,
      input ingress_valid,
      output ingress_ready,
      input ingress_first,
      input ingress_last,
      input ingress_tail_bytes,
      output egress_data,
      output egress_valid,
      input egress_ready,
      output egress_tail_bytes,
      output done,
      output sa_missing,
      output malformed_packet,
      output integrity_mismatch,
      output replay_reject,
      output unencrypted
   );

   modport host (
      output cen,
      output ingress_data,
      output ingress_valid,
      input ingress_ready,
      output ingress_first,
      output ingress_last,
      output ingress_tail_bytes,
      input egress_data,
      input egress_valid,
      output egress_ready,
      input egress_tail_bytes,
      input done,
      input sa_missing,
      input malformed_packet,
      input integrity_mismatch,
      input replay_reject,
      input unencrypted
   );
endinterface

// file: hdl/spsp_device.sv
// Contract
// - Enable low: inputs ignored, outputs meaningless
// - Upstream marks first word with first
// - Upstream marks final word with last
// - Ingress valid only with real word
// - Ingress ready only when word acceptable
// - Final ingress word carries tail count
// - Egress valid only with real word
// - Egress ready only when sink accepts
// - Egress tail count, all ones unless last
// - Done pulses; status gated by done
// - Flag missing security parameters
// - Flag malformed packet
// - Flag integrity value mismatch
// - Flag sequence number outside replay window
// - Flag unencrypted received packet
//
`timescale 1ns/1ps
module spsp_device #(
   parameter int MAX_WORDS = spsp_pkg::MAX_WORDS
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   spsp_if.dev link,
   input wire logic eng_sa_missing_i,
   input wire logic eng_integrity_mismatch_i,
   input wire logic eng_replay_reject_i,
   input wire logic eng_unencrypted_i,
   output logic pkt_active_o
);
   // Word index at which a packet still without last is malformed
   localparam logic [spsp_pkg::WCNT_W-1:0] WCNT_LAST =
      spsp_pkg::WCNT_W'(MAX_WORDS - 1);

   spsp_pkg::spsp_pkt_state_t state_q;
   spsp_pkg::spsp_pkt_state_t state_d;
   logic [spsp_pkg::WCNT_W-1:0] wcnt_q;
   logic [spsp_pkg::WCNT_W-1:0] wcnt_d;
   logic bad_q;
   logic bad_d;

   logic [spsp_pkg::DATA_W-1:0] eg_data_q;
   logic [spsp_pkg::DATA_W-1:0] eg_data_d;
   logic eg_valid_q;
   logic eg_valid_d;
   logic eg_last_q;
   logic eg_last_d;
   logic [spsp_pkg::TAIL_W-1:0] eg_tail_q;
   logic [spsp_pkg::TAIL_W-1:0] eg_tail_d;
   spsp_pkg::spsp_status_t pend_q;
   spsp_pkg::spsp_status_t pend_d;

   logic done_q;
   logic done_d;
   spsp_pkg::spsp_status_t stat_q;
   spsp_pkg::spsp_status_t stat_d;

   logic ing_ready;
   logic ing_take;
   logic eg_take;
   logic fmt_err;

   // Open packet test, shared by the format check and the status pin
   function automatic logic pkt_open(input spsp_pkg::spsp_pkt_state_t st);
      return st == spsp_pkg::SPSP_IN_PKT;
   endfunction

   // Enable gate on both handshakes
   // enable gates handshakes
   assign eg_take = link.cen & eg_valid_q & link.egress_ready;

   // One output stage; refills in the cycle it drains, so full rate
   // ready from stage
   assign ing_ready = link.cen & (~eg_valid_q | link.egress_ready);
   assign ing_take = ing_ready & link.ingress_valid;

   // Sequence check of the first markers and the packet length
   always_comb begin
      fmt_err = 1'b0;
      if (pkt_open(state_q) && link.ingress_first) begin
         fmt_err = 1'b1;
      end
      // A fault marks the whole packet; its words still pass unchanged
      if (!pkt_open(state_q) && !link.ingress_first) begin
         fmt_err = 1'b1;
      end
      if (wcnt_q == WCNT_LAST && !link.ingress_last) begin
         fmt_err = 1'b1;
      end
   end

   // Packet tracking
   always_comb begin
      state_d = state_q;
      wcnt_d = wcnt_q;
      bad_d = bad_q;
      if (ing_take) begin
         if (link.ingress_last) begin
            state_d = spsp_pkg::SPSP_IDLE;
            wcnt_d = spsp_pkg::WCNT_ZERO;
            bad_d = 1'b0;
         end else begin
            state_d = spsp_pkg::SPSP_IN_PKT;
            // Count saturates so an endless packet stays flagged
            if (wcnt_q != WCNT_LAST) begin
               wcnt_d = wcnt_q + spsp_pkg::WCNT_ONE;
            end
            bad_d = bad_q | fmt_err;
         end
      end
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_q <= spsp_pkg::SPSP_IDLE;
         wcnt_q <= spsp_pkg::WCNT_ZERO;
         bad_q <= 1'b0;
      end else begin
         state_q <= state_d;
         wcnt_q <= wcnt_d;
         bad_q <= bad_d;
      end
   end

   // Egress stage; the cipher datapath sits outside, words flow through
   always_comb begin
      eg_data_d = eg_data_q;
      eg_valid_d = eg_valid_q;
      eg_last_d = eg_last_q;
      eg_tail_d = eg_tail_q;
      pend_d = pend_q;
      if (ing_take) begin
         eg_valid_d = 1'b1;
         eg_data_d = link.ingress_data;
         eg_last_d = link.ingress_last;
         eg_tail_d = link.ingress_last ? link.ingress_tail_bytes : spsp_pkg::TAIL_FULL;
         if (link.ingress_last) begin
            // Verdicts are sampled with the last word; they travel with it
            // missing parameters verdict
            pend_d.sa_missing = eng_sa_missing_i;
            pend_d.malformed_packet = bad_q | fmt_err;
            pend_d.integrity_mismatch = eng_integrity_mismatch_i;
            pend_d.replay_reject = eng_replay_reject_i;
            pend_d.unencrypted = eng_unencrypted_i;
         end
      end else if (eg_take) begin
         eg_valid_d = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         eg_data_q <= spsp_pkg::DATA_ZERO;
         eg_valid_q <= 1'b0;
         eg_last_q <= 1'b0;
         eg_tail_q <= spsp_pkg::TAIL_FULL;
         pend_q <= spsp_pkg::STATUS_CLEAR;
      end else begin
         eg_data_q <= eg_data_d;
         eg_valid_q <= eg_valid_d;
         eg_last_q <= eg_last_d;
         eg_tail_q <= eg_tail_d;
         pend_q <= pend_d;
      end
   end

   // Completion after the last word has left; flags read zero otherwise
   always_comb begin
      done_d = eg_take & eg_last_q;
      stat_d = done_d ? pend_q : spsp_pkg::STATUS_CLEAR;
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         done_q <= 1'b0;
         stat_q <= spsp_pkg::STATUS_CLEAR;
      end else begin
         done_q <= done_d;
         stat_q <= stat_d;
      end
   end

   assign link.ingress_ready = ing_ready;
   assign link.egress_data = eg_data_q;
   assign link.egress_valid = eg_valid_q;
   assign link.egress_tail_bytes = eg_tail_q;
   assign link.done = done_q;
   // Flags read low outside the done cycle, so a host may simply OR them
   assign link.sa_missing = stat_q.sa_missing;
   assign link.malformed_packet = stat_q.malformed_packet;
   assign link.integrity_mismatch = stat_q.integrity_mismatch;
   assign link.replay_reject = stat_q.replay_reject;
   assign link.unencrypted = stat_q.unencrypted;
   assign pkt_active_o = pkt_open(state_q);
endmodule

// file: hdl/spsp_host.sv
`timescale 1ns/1ps
module spsp_host (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   spsp_if.host link,
   input wire logic enable_i,
   input wire logic [spsp_pkg::DATA_W-1:0] src_data_i,
   input wire logic src_valid_i,
   input wire logic src_last_i,
   input wire logic [spsp_pkg::TAIL_W-1:0] src_tail_i,
   output logic src_ready_o,
   output logic [spsp_pkg::DATA_W-1:0] snk_data_o,
   output logic [spsp_pkg::TAIL_W-1:0] snk_tail_o,
   output logic snk_valid_o,
   input wire logic snk_ready_i,
   output logic res_valid_o,
   output logic [4:0] res_flags_o
);
   spsp_pkg::spsp_pkt_state_t state_q;
   spsp_pkg::spsp_pkt_state_t state_d;
   logic [spsp_pkg::DATA_W-1:0] data_q;
   logic [spsp_pkg::DATA_W-1:0] data_d;
   logic valid_q;
   logic valid_d;
   logic first_q;
   logic first_d;
   logic last_q;
   logic last_d;
   logic [spsp_pkg::TAIL_W-1:0] tail_q;
   logic [spsp_pkg::TAIL_W-1:0] tail_d;
   logic res_valid_q;
   logic res_valid_d;
   spsp_pkg::spsp_status_t res_q;
   spsp_pkg::spsp_status_t res_d;
   logic xfer;
   logic load;

   // device outputs used only while enabled
   assign xfer = enable_i & valid_q & link.ingress_ready;
   assign src_ready_o = ~valid_q | xfer;
   assign load = src_ready_o & src_valid_i;

   always_comb begin
      state_d = state_q;
      data_d = data_q;
      valid_d = valid_q;
      first_d = first_q;
      last_d = last_q;
      tail_d = tail_q;
      if (xfer) begin
         state_d = last_q ? spsp_pkg::SPSP_IDLE : spsp_pkg::SPSP_IN_PKT;
         valid_d = 1'b0;
      end
      if (load) begin
         valid_d = 1'b1;
         data_d = src_data_i;
         first_d = (state_d == spsp_pkg::SPSP_IDLE);
         last_d = src_last_i;
         tail_d = src_last_i ? src_tail_i : spsp_pkg::TAIL_FULL;
      end
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_q <= spsp_pkg::SPSP_IDLE;
         data_q <= spsp_pkg::DATA_ZERO;
         valid_q <= 1'b0;
         first_q <= 1'b0;
         last_q <= 1'b0;
         tail_q <= spsp_pkg::TAIL_FULL;
      end else begin
         state_q <= state_d;
         data_q <= data_d;
         valid_q <= valid_d;
         first_q <= first_d;
         last_q <= last_d;
         tail_q <= tail_d;
      end
   end

   // Completion capture; status ignored unless done and enabled
   always_comb begin
      res_valid_d = enable_i & link.done;
      res_d = spsp_pkg::STATUS_CLEAR;
      if (res_valid_d) begin
         res_d.sa_missing = link.sa_missing;
         res_d.malformed_packet = link.malformed_packet;
         res_d.integrity_mismatch = link.integrity_mismatch;
         res_d.replay_reject = link.replay_reject;
         res_d.unencrypted = link.unencrypted;
      end
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         res_valid_q <= 1'b0;
         res_q <= spsp_pkg::STATUS_CLEAR;
      end else begin
         res_valid_q <= res_valid_d;
         res_q <= res_d;
      end
   end

   assign link.cen = enable_i;
   assign link.ingress_data = data_q;
   assign link.ingress_valid = valid_q;
   assign link.ingress_first = first_q;
   assign link.ingress_last = last_q;
   assign link.ingress_tail_bytes = tail_q;
   assign link.egress_ready = enable_i & snk_ready_i;
   assign snk_valid_o = enable_i & link.egress_valid;
   assign snk_data_o = link.egress_data;
   assign snk_tail_o = link.egress_tail_bytes;
   assign res_valid_o = res_valid_q;
   assign res_flags_o = res_q;
endmodule

// file: tb/spsp_props.sv
`timescale 1ns/1ps
module spsp_props (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic cen,
   input wire logic [127:0] ingress_data,
   input wire logic ingress_valid,
   input wire logic ingress_ready,
   input wire logic ingress_last,
   input wire logic [3:0] ingress_tail_bytes,
   input wire logic [127:0] egress_data,
   input wire logic egress_valid,
   input wire logic egress_ready,
   input wire logic [3:0] egress_tail_bytes,
   input wire logic done,
   input wire logic sa_missing,
   input wire logic malformed_packet,
   input wire logic integrity_mismatch,
   input wire logic replay_reject,
   input wire logic unencrypted
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   logic last_q;
   wire logic take = cen && ingress_valid && ingress_ready;
   wire logic give = cen && egress_valid && egress_ready;
   // Tracks whether the word on egress closes its packet
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         last_q <= 1'b0;
      end else if (take) begin
         last_q <= ingress_last;
      end
   end
   a_ready_needs_room: assert property (
      ingress_ready == (cen && (!egress_valid || egress_ready))) else $error("bad ready");
   a_word_moves_out: assert property (
      take |=> egress_valid && egress_data == $past(ingress_data)) else $error("word lost");
   a_word_holds_still: assert property (
      egress_valid && !give |=> egress_valid && $stable(egress_data)
      && $stable(egress_tail_bytes)) else $error("word changed");
   a_tail_mid_full: assert property (
      take && !ingress_last |=> egress_tail_bytes == spsp_pkg::TAIL_FULL) else $error("mid tail");
   a_tail_last_copy: assert property (
      take && ingress_last |=> egress_tail_bytes == $past(ingress_tail_bytes))
      else $error("last tail");
   a_done_after_last: assert property (
      done == $past(give && last_q)) else $error("done timing");
   a_flags_need_done: assert property (
      !done |-> {sa_missing, malformed_packet, integrity_mismatch, replay_reject,
      unencrypted} == 5'h00) else $error("flag outside done");
   a_reset_leaves_idle: assert property (
      $fell(sys_rst_i) |-> !egress_valid && !done) else $error("not idle");
   c_malformed: cover property (done && malformed_packet);
   c_disabled_hold: cover property (!cen && ingress_valid);
   c_sink_stall: cover property (cen && egress_valid && !egress_ready);
endmodule

// file: tb/secure_packet_stream_port_tb.sv
`timescale 1ns/1ps
module secure_packet_stream_port_tb;
   logic clk_sys_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic enable_i = 1'b0;
   logic [127:0] src_data_i = 128'h0;
   logic src_valid_i = 1'b0;
   logic src_last_i = 1'b0;
   logic [3:0] src_tail_i = 4'hF;
   logic snk_ready_i = 1'b1;
   logic [3:0] eng_i = 4'h0;
   logic stall = 1'b0;
   logic src_ready_o, snk_valid_o, res_valid_o, pkt_active_o;
   logic [127:0] snk_data_o;
   logic [3:0] snk_tail_o;
   logic [4:0] res_flags_o;
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [127:0] gd[$];
   logic [3:0] gt[$];
   logic [4:0] gf[$];
   spsp_if link ();
   spsp_device #(.MAX_WORDS(8)) i_spsp_device (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .link(link), .eng_sa_missing_i(eng_i[3]), .eng_integrity_mismatch_i(eng_i[2]),
      .eng_replay_reject_i(eng_i[1]), .eng_unencrypted_i(eng_i[0]),
      .pkt_active_o(pkt_active_o));
   spsp_host i_spsp_host (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .link(link),
      .enable_i(enable_i), .src_data_i(src_data_i), .src_valid_i(src_valid_i),
      .src_last_i(src_last_i), .src_tail_i(src_tail_i), .src_ready_o(src_ready_o),
      .snk_data_o(snk_data_o), .snk_tail_o(snk_tail_o), .snk_valid_o(snk_valid_o),
      .snk_ready_i(snk_ready_i), .res_valid_o(res_valid_o), .res_flags_o(res_flags_o));
   spsp_props i_props (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .cen(link.cen),
      .ingress_data(link.ingress_data), .ingress_valid(link.ingress_valid),
      .ingress_ready(link.ingress_ready), .ingress_last(link.ingress_last),
      .ingress_tail_bytes(link.ingress_tail_bytes), .egress_data(link.egress_data),
      .egress_valid(link.egress_valid), .egress_ready(link.egress_ready),
      .egress_tail_bytes(link.egress_tail_bytes), .done(link.done),
      .sa_missing(link.sa_missing), .malformed_packet(link.malformed_packet),
      .integrity_mismatch(link.integrity_mismatch), .replay_reject(link.replay_reject),
      .unencrypted(link.unencrypted));
   initial begin
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   // Ceiling far above the hundred or so cycles the tests need
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         $display("[ERR] %0t timeout", $time);
         report_and_stop();
      end
   end
   // Sink ready toggles when stalling so words wait on the link
   always @(posedge clk_sys_i) begin
      #2 snk_ready_i = !stall || !snk_ready_i;
   end
   // Sampled mid-cycle, where every flop and input has settled
   always @(negedge clk_sys_i) begin
      if (snk_valid_o === 1'b1 && snk_ready_i === 1'b1) begin
         gd.push_back(snk_data_o);
         gt.push_back(snk_tail_o);
      end
      if (res_valid_o === 1'b1) begin
         gf.push_back(res_flags_o);
      end
   end
   function automatic logic [127:0] word(input int i);
      return {8{16'h5A00 + 16'(i)}};
   endfunction
   task automatic report_and_stop();
      $display("comparisons %0d errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk_data(input logic [127:0] got, input logic [127:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t data %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_small(input logic [4:0] got, input logic [4:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t %s %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic send_pkt(input int n, input logic [3:0] tail);
      for (int i = 0; i < n; i++) begin
         src_data_i = word(i);
         src_valid_i = 1'b1;
         src_last_i = (i == n - 1);
         src_tail_i = (i == n - 1) ? tail : 4'hF;
         // Ready judged mid-cycle, after every #2 input change has settled
         @(negedge clk_sys_i);
         while (src_ready_o !== 1'b1) begin
            @(negedge clk_sys_i);
         end
         @(posedge clk_sys_i);
         #2;
      end
      src_valid_i = 1'b0;
      src_last_i = 1'b0;
   endtask
   task automatic run_pkt(input int n, input logic [3:0] tail, input logic [3:0] eng,
         input logic mal);
      gd.delete();
      gt.delete();
      gf.delete();
      eng_i = eng;
      send_pkt(n, tail);
      while (gf.size() == 0) begin
         @(posedge clk_sys_i);
         #2;
      end
      eng_i = 4'h0;
      chk_small(5'(gd.size()), 5'(n), "count");
      for (int i = 0; i < gd.size(); i++) begin
         chk_data(gd[i], word(i));
         chk_small({1'b0, gt[i]}, {1'b0, (i == n - 1) ? tail : 4'hF}, "tail");
      end
      chk_small(gf[0], {eng[3], mal, eng[2:0]}, "flags");
      chk_small({4'h0, pkt_active_o}, 5'h00, "open");
   endtask
   initial begin
      repeat (12) @(posedge clk_sys_i);
      #2;
      sys_rst_i = 1'b0;
      enable_i = 1'b1;
      chk_small({3'h0, snk_valid_o, res_valid_o}, 5'h00, "idle");
      run_pkt(1, 4'h5, 4'h0, 1'b0);
      stall = 1'b1;
      run_pkt(3, 4'h2, 4'h2, 1'b0);
      stall = 1'b0;
      for (int k = 0; k < 4; k++) begin
         run_pkt(2, 4'h7, 4'h1 << k, 1'b0);
      end
      run_pkt(8, 4'hB, 4'h0, 1'b0);
      run_pkt(9, 4'h3, 4'h0, 1'b1);
      enable_i = 1'b0;
      fork
         run_pkt(2, 4'h9, 4'h0, 1'b0);
         begin
            repeat (8) @(posedge clk_sys_i);
            #2;
            chk_small(5'(gd.size()), 5'h00, "disabled");
            chk_small({4'h0, link.egress_valid}, 5'h00, "ignored");
            enable_i = 1'b1;
         end
      join
      // Leave a packet open so the reset has state to clear
      src_data_i = word(0);
      src_valid_i = 1'b1;
      @(posedge clk_sys_i);
      #2;
      src_valid_i = 1'b0;
      repeat (2) @(posedge clk_sys_i);
      #2;
      chk_small({4'h0, pkt_active_o}, 5'h01, "open");
      sys_rst_i = 1'b1;
      @(posedge clk_sys_i);
      #2;
      chk_small({2'h0, pkt_active_o, snk_valid_o, res_valid_o}, 5'h00, "idle");
      sys_rst_i = 1'b0;
      run_pkt(1, 4'h0, 4'hF, 1'b0);
      report_and_stop();
   end
endmodule
